// >>> phy_basic_params.svh
// constants for the transceiver basic control and status register bank
// assumes inclusion by bare name from the design module and the testbench
`ifndef PHY_BASIC_PARAMS_SVH
`define PHY_BASIC_PARAMS_SVH

// register indexes on the management access path
`define IDX_BASIC_CONTROL 5'h00
`define IDX_BASIC_STATUS  5'h01

// control field positions
`define CTL_SOFT_RESET  15
`define CTL_LOOPBACK    14
`define CTL_SPEED       13
`define CTL_AUTONEG_EN  12
`define CTL_POWER_DOWN  11
`define CTL_AN_RESTART  9
`define CTL_DUPLEX      8
`define CTL_COL_TEST    7

// status field positions
`define STS_T4_ABLE     15
`define STS_AN_DONE     5
`define STS_REM_FAULT   4
`define STS_AN_ABLE     3
`define STS_LINK        2
`define STS_JABBER      1
`define STS_EXT_CAP     0

// fixed ability bits of the status word: 14..11, 3 and 0 set, 15 clear
`define STS_FIXED_MASK  16'h7809
// writable control bits; everything else is reserved and drops writes
`define CTL_WRITE_MASK  16'hfb80
`define CTL_RESET_VALUE 16'h1000

// cycles the soft reset pulse is held before the reset bit self-clears
`define SOFT_RESET_CYCLES 4'h8

`endif

// >>> phy_basic_pkg.sv
// types shared by the basic control and status register bank
// assumes the params header sits in the same folder
package phy_basic_pkg;
   typedef enum logic [2:0] {
      SR_IDLE  = 3'b001,
      SR_HOLD  = 3'b010,
      SR_DONE  = 3'b100
   } soft_reset_state_t;
endpackage

// >>> phy_basic_control_status.sv
// basic control and basic status registers of a 10/100 transceiver
// assumes the mac reaches it by index through its management access
// logic, one read or write strobe per access, synchronous to clk_sys
//
// Functional notes
// - writing control bit 15 starts soft reset; bit clears itself when done
// - control bit 14 selects loopback; resets to zero
// - control bit 13 picks 100 or 10 Mbps; ignored while autoneg enabled
// - control bit 8 picks full or half duplex; ignored while autoneg enabled
// - control bit 12 enables autoneg, overriding speed and duplex; resets to one
// - speed and duplex reset values come from the negotiation result
// - control bit 11 enters power down; resets to zero
// - after power down clears, negotiation completion sets status bit 5
// - writing control bit 9 restarts autoneg; bit clears itself afterwards
// - control bit 7 enables collision test; resets to zero
// - status bit 15 reads zero; bits 14 to 11 read one
// - status bit 5 shows negotiation complete; zero after reset
// - status bit 4 latches high on remote fault
// - status bit 3 always reads one
// - status bit 2 latches low on any link loss; zero after reset
// - status bit 1 latches high on jabber
// - status bit 0 always reads one
// - registers reached only by index through the mac management path
// - kept-across-soft-reset fields survive only the bit 15 reset
`timescale 1ns/10ps
`include "phy_basic_params.svh"

module phy_basic_control_status
   import phy_basic_pkg::*;
#(
   parameter int IDX_W = 5                    // width of the register index
) (
   input  wire logic             clk_sys,       // system clock, 250 MHz
   input  wire logic             resetn,        // async chip reset, active low
   input  wire logic             clkEn,         // freezes all state while low
   input  wire logic [IDX_W-1:0] regIdx,        // register index of the access
   input  wire logic             wrStrobe,      // one-cycle write request
   input  wire logic             rdStrobe,      // one-cycle read request
   input  wire logic [15:0]      wrData,        // write data
   input  wire logic             anDone,        // negotiation finished, level
   input  wire logic             anSpeed100,    // negotiated speed is 100 Mbps
   input  wire logic             anFullDuplex,  // negotiated duplex is full
   input  wire logic             linkUp,        // current link condition
   input  wire logic             remFault,      // current remote fault condition
   input  wire logic             jabber,        // current jabber condition
   output logic [15:0]           rdData,        // read data, registered
   output logic                  rdValid,       // read data valid pulse
   output logic                  softResetOut,  // transceiver soft reset level
   output logic                  loopbackEn,    // loopback mode
   output logic                  speed100,      // effective speed, negotiated with autoneg on, else manual
   output logic                  fullDuplex,    // effective duplex, negotiated with autoneg on, else manual
   output logic                  anEnable,      // negotiation enabled
   output logic                  anRestart,     // negotiation restart pulse
   output logic                  powerDown,     // general power down
   output logic                  colTest        // collision signal test
);

   ////////////////////////////////////////////////////////////////////////////
   // control register state

   logic [15:0]       ctl_reg;
   logic [15:0]       ctl_next;
   soft_reset_state_t srState_reg;
   logic [3:0]        srCount_reg;
   logic              speedSeed_reg;
   logic              duplexSeed_reg;
   logic              seedPending_reg;
   logic              fault_reg;
   logic              jab_reg;
   logic              link_reg;
   logic              anDone_reg;

   logic wrCtl;
   logic wrSts;
   logic rdSts;
   logic srRunning;

   // accesses are decoded only by index; no address map exists
   assign wrCtl = clkEn && wrStrobe && (regIdx == IDX_W'(`IDX_BASIC_CONTROL));
   assign wrSts = clkEn && wrStrobe && (regIdx == IDX_W'(`IDX_BASIC_STATUS));
   assign rdSts = clkEn && rdStrobe && (regIdx == IDX_W'(`IDX_BASIC_STATUS));
   assign srRunning = (srState_reg != SR_IDLE);

   // next control word; writes during soft reset are dropped since the
   // bank is being reinitialised and a late write would be half-applied
   always_comb begin
      ctl_next = ctl_reg;
      if (srState_reg == SR_DONE) begin
         // soft reset restores defaults, bit 15 self-clears
         ctl_next = `CTL_RESET_VALUE;
         ctl_next[`CTL_SPEED]  = anSpeed100;
         ctl_next[`CTL_DUPLEX] = anFullDuplex;
      end else if (wrCtl && !srRunning) begin
         ctl_next = wrData & `CTL_WRITE_MASK;    // reserved bits dropped
      end else begin
         ctl_next[`CTL_AN_RESTART] = 1'b0;       // restart self-clears
      end
   end

   // control register; speed and duplex are seeded once from the
   // negotiation result after chip reset
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         ctl_reg <= `CTL_RESET_VALUE;
      end else if (clkEn) begin
         ctl_reg <= ctl_next;
         if (seedPending_reg && !wrCtl) begin
            ctl_reg[`CTL_SPEED]  <= anSpeed100;
            ctl_reg[`CTL_DUPLEX] <= anFullDuplex;
         end
      end
   end

   // the seed is taken at the first enabled edge after release, never
   // inside the async reset branch
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         seedPending_reg <= 1'b1;
      end else if (clkEn) begin
         seedPending_reg <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // soft reset sequencer

   // a write of bit 15 holds the transceiver in reset for a fixed count,
   // then reloads defaults and lets bit 15 fall
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         srState_reg <= SR_IDLE;
         srCount_reg <= 4'h0;
      end else if (clkEn) begin
         unique case (srState_reg)
            SR_IDLE: begin
               if (wrCtl && wrData[`CTL_SOFT_RESET]) begin
                  srState_reg <= SR_HOLD;
                  srCount_reg <= `SOFT_RESET_CYCLES;
               end
            end
            SR_HOLD: begin
               srCount_reg <= srCount_reg - 4'h1;
               if (srCount_reg == 4'h1) begin
                  srState_reg <= SR_DONE;
               end
            end
            SR_DONE: begin
               srState_reg <= SR_IDLE;
            end
            default: begin
               srState_reg <= SR_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // status latches

   // latch-high fault and jabber, latch-low link; a read releases them to
   // the present condition, and an event in the read cycle still wins
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         fault_reg <= 1'b0;
         jab_reg   <= 1'b0;
         link_reg  <= 1'b0;
      end else if (clkEn) begin
         fault_reg <= remFault | (fault_reg & !rdSts);
         jab_reg   <= jabber | (jab_reg & !rdSts);
         link_reg  <= linkUp & (link_reg | rdSts);
      end
   end

   // completion flag follows the engine; power down or restart drops it
   // only for the cycles that control bit is set
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         anDone_reg <= 1'b0;
      end else if (clkEn) begin
         anDone_reg <= anDone && !ctl_reg[`CTL_POWER_DOWN] && !ctl_reg[`CTL_AN_RESTART];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read port

   logic [15:0] stsWord;

   // fixed ability bits plus live and latched bits
   always_comb begin
      stsWord = `STS_FIXED_MASK;
      stsWord[`STS_AN_DONE]   = anDone_reg;
      stsWord[`STS_REM_FAULT] = fault_reg;
      stsWord[`STS_LINK]      = link_reg;
      stsWord[`STS_JABBER]    = jab_reg;
   end

   // registered read answer one cycle after the strobe; the status word is
   // read-only so status writes are ignored
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         rdData  <= 16'h0000;
         rdValid <= 1'b0;
      end else if (clkEn) begin
         rdValid <= rdStrobe;
         if (rdStrobe && regIdx == IDX_W'(`IDX_BASIC_CONTROL)) begin
            rdData <= ctl_reg;
         end else if (rdSts) begin
            rdData <= stsWord;
         end else if (rdStrobe) begin
            rdData <= 16'h0000;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // control outputs

   // manual speed and duplex only take effect with negotiation off
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         softResetOut <= 1'b0;
         loopbackEn   <= 1'b0;
         speed100     <= 1'b0;
         fullDuplex   <= 1'b0;
         anEnable     <= 1'b1;
         anRestart    <= 1'b0;
         powerDown    <= 1'b0;
         colTest      <= 1'b0;
      end else if (clkEn) begin
         softResetOut <= (srState_reg == SR_HOLD);
         loopbackEn   <= ctl_reg[`CTL_LOOPBACK];
         speed100     <= ctl_reg[`CTL_AUTONEG_EN] ? anSpeed100
                                                  : ctl_reg[`CTL_SPEED];
         fullDuplex   <= ctl_reg[`CTL_AUTONEG_EN] ? anFullDuplex
                                                  : ctl_reg[`CTL_DUPLEX];
         anEnable     <= ctl_reg[`CTL_AUTONEG_EN];
         anRestart    <= ctl_reg[`CTL_AN_RESTART];
         powerDown    <= ctl_reg[`CTL_POWER_DOWN];
         colTest      <= ctl_reg[`CTL_COL_TEST];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // assertions

   soft_reset_clears_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      (clkEn && srState_reg == SR_DONE) |=> !ctl_reg[`CTL_SOFT_RESET])
      else $error("soft reset bit did not self-clear");

   restart_pulse_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      (clkEn && ctl_reg[`CTL_AN_RESTART] && !wrCtl) |=> !ctl_reg[`CTL_AN_RESTART])
      else $error("restart bit stuck");

   manual_speed_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      (clkEn && !ctl_reg[`CTL_AUTONEG_EN]) |=> (!clkEn || speed100 == $past(ctl_reg[`CTL_SPEED])))
      else $error("manual speed not applied");

   auto_duplex_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      (clkEn && ctl_reg[`CTL_AUTONEG_EN]) |=> (!clkEn || fullDuplex == $past(anFullDuplex)))
      else $error("duplex not taken from negotiation");

   fixed_bits_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      rdSts |=> (rdData[15:11] == 5'h0f && rdData[10:6] == 5'h00 && rdData[3] && rdData[0]))
      else $error("fixed ability bits wrong");

   fault_hold_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      (clkEn && remFault) |=> fault_reg)
      else $error("remote fault not latched");

   jabber_hold_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      (clkEn && jab_reg && !rdSts) |=> jab_reg)
      else $error("jabber latch released without read");

   link_low_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      (clkEn && !linkUp) ##1 (clkEn && !rdSts)[*2] |-> !link_reg)
      else $error("link latch not held low");

   an_done_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      (clkEn && ctl_reg[`CTL_POWER_DOWN]) |=> !anDone_reg)
      else $error("completion shown during power down");

   reserved_ctl_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      (ctl_reg & ~`CTL_WRITE_MASK) == 16'h0000)
      else $error("reserved control bit set");

   status_write_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      (wrSts && !srRunning && !ctl_reg[`CTL_AN_RESTART] && !seedPending_reg)
         |=> ctl_reg == $past(ctl_reg))
      else $error("status write changed control");

   loopback_out_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      clkEn |=> loopbackEn == $past(ctl_reg[`CTL_LOOPBACK]))
      else $error("loopback output lags control bit");

   manual_duplex_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      (clkEn && !ctl_reg[`CTL_AUTONEG_EN]) |=> fullDuplex == $past(ctl_reg[`CTL_DUPLEX]))
      else $error("manual duplex not applied");

   auto_speed_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      (clkEn && ctl_reg[`CTL_AUTONEG_EN] && !seedPending_reg) |=> speed100 == $past(anSpeed100))
      else $error("speed not taken from negotiation");

   an_enable_out_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      clkEn |=> anEnable == $past(ctl_reg[`CTL_AUTONEG_EN]))
      else $error("negotiation enable output lags control bit");

   power_down_out_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      clkEn |=> powerDown == $past(ctl_reg[`CTL_POWER_DOWN]))
      else $error("power down output lags control bit");

   col_test_out_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      clkEn |=> colTest == $past(ctl_reg[`CTL_COL_TEST]))
      else $error("collision test output lags control bit");

   restart_out_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      clkEn |=> anRestart == $past(ctl_reg[`CTL_AN_RESTART]))
      else $error("restart output lags control bit");

   soft_reset_hold_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      (clkEn && srState_reg == SR_HOLD) |=> softResetOut)
      else $error("soft reset output not held");

   soft_reload_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      (clkEn && srState_reg == SR_DONE) |=> (ctl_reg[`CTL_SPEED] == $past(anSpeed100)
         && ctl_reg[`CTL_DUPLEX] == $past(anFullDuplex) && ctl_reg[`CTL_AUTONEG_EN]))
      else $error("soft reset reload wrong");

   link_release_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      rdSts |=> link_reg == $past(linkUp))
      else $error("link latch not released by read");

   fault_release_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      rdSts |=> fault_reg == $past(remFault))
      else $error("fault latch not released by read");

   an_done_ok_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      (clkEn && anDone && !ctl_reg[`CTL_POWER_DOWN] && !ctl_reg[`CTL_AN_RESTART]) |=> anDone_reg)
      else $error("completion not shown");

   rd_valid_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      clkEn |=> rdValid == $past(rdStrobe))
      else $error("read valid does not follow strobe");

   unmapped_read_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      (clkEn && rdStrobe && regIdx != IDX_W'(`IDX_BASIC_CONTROL)
         && regIdx != IDX_W'(`IDX_BASIC_STATUS)) |=> rdData == 16'h0000)
      else $error("unmapped index read not zero");

   ctl_read_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      (clkEn && rdStrobe && regIdx == IDX_W'(`IDX_BASIC_CONTROL)) |=> rdData == $past(ctl_reg))
      else $error("control read data wrong");

   freeze_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      !clkEn |=> (ctl_reg == $past(ctl_reg) && rdValid == $past(rdValid)))
      else $error("state moved with clock enable low");

endmodule

// >>> mgmt_host_model.sv
// host side model: indexed register access as the mac management logic does it
// assumes one clock shared with the register bank and one request at a time
`timescale 1ns/10ps

module mgmt_host_model (
   input  wire logic        clk_sys,   // system clock
   input  wire logic [15:0] rdData,    // read data from the bank
   input  wire logic        rdValid,   // read data valid pulse
   output logic [4:0]       regIdx,    // register index
   output logic             wrStrobe,  // write request
   output logic             rdStrobe,  // read request
   output logic [15:0]      wrData     // write data
);

   // idle values at time zero, no request pending
   initial begin
      regIdx   = 5'h1f;
      wrStrobe = 1'b0;
      rdStrobe = 1'b0;
      wrData   = 16'h0000;
   end

   ////////////////////////////////////////////////////////////////////////
   // one write by index; released lines turn over so stale data never looks live
   task automatic wr(input logic [4:0] idx, input logic [15:0] d);
      @(posedge clk_sys);
      regIdx   <= idx;
      wrData   <= d;
      wrStrobe <= 1'b1;
      @(posedge clk_sys);
      wrStrobe <= 1'b0;
      regIdx   <= ~idx;
      wrData   <= ~d;
   endtask

   // one read by index; the wait for valid is bounded so a dead bank cannot hang us
   task automatic rd(input logic [4:0] idx, output logic [15:0] d);
      int n;
      @(posedge clk_sys);
      regIdx   <= idx;
      rdStrobe <= 1'b1;
      @(posedge clk_sys);
      rdStrobe <= 1'b0;
      regIdx   <= ~idx;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (rdValid !== 1'b1 && n < 8);
      // a missing answer comes back unknown so the caller's compare counts it
      d = (rdValid === 1'b1) ? rdData : 16'hxxxx;
   endtask

endmodule

// >>> phy_basic_control_status_tb_top.sv
// testbench for the basic control and status register bank
// assumes the host model drives the access path and the bench the line conditions
`timescale 1ns/10ps
`include "phy_basic_params.svh"

module phy_basic_control_status_tb_top;

   logic        clk_sys, resetn, clkEn, wrStrobe, rdStrobe, rdValid;
   logic        anDone, anSpeed100, anFullDuplex, linkUp, remFault, jabber;
   logic        softResetOut, loopbackEn, speed100, fullDuplex;
   logic        anEnable, anRestart, powerDown, colTest;
   logic [4:0]  regIdx;
   logic [15:0] wrData, rdData, restartCnt, softCnt;
   int          numErrors, checksDone;

   phy_basic_control_status dut_u (.clk_sys(clk_sys), .resetn(resetn), .clkEn(clkEn),
      .regIdx(regIdx), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .wrData(wrData),
      .anDone(anDone), .anSpeed100(anSpeed100), .anFullDuplex(anFullDuplex),
      .linkUp(linkUp), .remFault(remFault), .jabber(jabber), .rdData(rdData),
      .rdValid(rdValid), .softResetOut(softResetOut), .loopbackEn(loopbackEn),
      .speed100(speed100), .fullDuplex(fullDuplex), .anEnable(anEnable),
      .anRestart(anRestart), .powerDown(powerDown), .colTest(colTest));

   mgmt_host_model host_u (.clk_sys(clk_sys), .rdData(rdData), .rdValid(rdValid),
      .regIdx(regIdx), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .wrData(wrData));

   ////////////////////////////////////////////////////////////////////////
   // 250 MHz clock
   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end

   // pulse counters; a stuck restart shows up as a count above one, a stuck soft reset as a count above eight
   always @(posedge clk_sys) begin
      if (anRestart === 1'b1) restartCnt <= restartCnt + 16'h0001;
      if (softResetOut === 1'b1) softCnt <= softCnt + 16'h0001;
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic chk16(input string what, input logic [15:0] exp, input logic [15:0] got);
      checksDone++;
      if (got !== exp) begin
         numErrors++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic chk1(input string what, input logic exp, input logic got);
      checksDone++;
      if (got !== exp) begin
         numErrors++;
         $display("[ERR] %s expected %b seen %b", what, exp, got);
      end
   endtask

   task automatic rdChk(input logic [4:0] idx, input logic [15:0] exp, input string what);
      logic [15:0] v;
      host_u.rd(idx, v);
      chk16(what, exp, v);
   endtask

   task automatic testDone;
      if (numErrors == 0 && checksDone > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // watchdog: the whole sequence needs well under a thousand cycles
   initial begin
      #40000;
      numErrors++;
      testDone;
   end

   ////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      numErrors = 0;
      checksDone = 0;
      restartCnt = 16'h0000;
      softCnt = 16'h0000;
      resetn = 1'b0;
      clkEn = 1'b1;
      anDone = 1'b1;
      anSpeed100 = 1'b1;
      anFullDuplex = 1'b0;
      linkUp = 1'b1;
      remFault = 1'b0;
      jabber = 1'b0;
      repeat (12) @(posedge clk_sys);
      resetn <= 1'b1;
      rdChk(5'h00, 16'h3000, "ctl after reset");
      chk1("anEnable", 1'b1, anEnable);
      rdChk(5'h01, 16'h7829, "sts first");
      rdChk(5'h01, 16'h782d, "sts released");
      // short line faults, gone again before the read
      @(posedge clk_sys);
      linkUp <= 1'b0;
      remFault <= 1'b1;
      jabber <= 1'b1;
      @(posedge clk_sys);
      linkUp <= 1'b1;
      remFault <= 1'b0;
      jabber <= 1'b0;
      rdChk(5'h01, 16'h783b, "sts latched");
      rdChk(5'h01, 16'h782d, "sts cleared");
      // manual mode, reserved bits set in the write
      host_u.wr(5'h00, 16'h45ff);
      rdChk(5'h00, 16'h4180, "ctl manual");
      chk1("loopbackEn", 1'b1, loopbackEn);
      chk1("speed100", 1'b0, speed100);
      chk1("fullDuplex", 1'b1, fullDuplex);
      chk1("colTest", 1'b1, colTest);
      chk1("anEnable", 1'b0, anEnable);
      // negotiation enabled overrides the manual bits
      host_u.wr(5'h00, 16'h3100);
      rdChk(5'h00, 16'h3100, "ctl autoneg");
      chk1("speed100", 1'b1, speed100);
      chk1("fullDuplex", 1'b0, fullDuplex);
      // power down, then negotiation finishing afterwards
      host_u.wr(5'h00, 16'h1800);
      repeat (2) @(posedge clk_sys);
      chk1("powerDown", 1'b1, powerDown);
      rdChk(5'h01, 16'h780d, "sts power down");
      anDone <= 1'b0;
      host_u.wr(5'h00, 16'h1000);
      rdChk(5'h01, 16'h780d, "sts negotiating");
      anDone <= 1'b1;
      rdChk(5'h01, 16'h782d, "sts negotiated");
      // restart is a single pulse and the bit clears itself
      host_u.wr(5'h00, 16'h1200);
      rdChk(5'h00, 16'h1000, "ctl restart");
      chk16("restart pulses", 16'h0001, restartCnt);
      host_u.wr(5'h01, 16'h0000);
      rdChk(5'h01, 16'h782d, "sts write");
      rdChk(5'h05, 16'h0000, "unmapped");
      // soft reset with a jabber latched and a write refused mid-hold
      @(posedge clk_sys);
      jabber <= 1'b1;
      @(posedge clk_sys);
      jabber <= 1'b0;
      host_u.wr(5'h00, 16'h4000);
      host_u.wr(5'h00, 16'h8000);
      host_u.wr(5'h00, 16'h4000);
      repeat (16) @(posedge clk_sys);
      chk16("soft reset cycles", {12'h000, `SOFT_RESET_CYCLES}, softCnt);
      rdChk(5'h00, 16'h3000, "ctl soft reset");
      chk1("loopbackEn", 1'b0, loopbackEn);
      rdChk(5'h01, 16'h782f, "sts soft reset");
      // clock enable low: a fault and a write in the frozen span leave no trace
      @(posedge clk_sys);
      clkEn <= 1'b0;
      remFault <= 1'b1;
      host_u.wr(5'h00, 16'h4000);
      remFault <= 1'b0;
      @(posedge clk_sys);
      clkEn <= 1'b1;
      rdChk(5'h00, 16'h3000, "ctl frozen");
      rdChk(5'h01, 16'h782d, "sts frozen");
      testDone;
   end

endmodule
